// ---- core/bridge_pkg.sv ----
/*
  Shared constants for the phase-clock to strobe bus bridge.
  Assumes a single 25 MHz clock domain and synchronous active-high reset.
*/
package bridge_pkg;

  // Width of the processor-side low address bus.
  localparam int ADDR_LO_W = 16;
  // Width of the upper address bus on the extended connector.
  localparam int ADDR_HI_W = 8;
  // Width of the data bus.
  localparam int DATA_W = 8;
  // Upper address byte that selects the I/O window by default.
  localparam logic [7:0] IO_PAGE_RESET = 8'hfe;
  // Nominal phase-clock divide ratio from mclk (one period is this many cycles).
  localparam int PHASE_DIV = 12;
  // Cycles before the end of the valid half that the write strobe is cut.
  localparam int WR_CUT_CYCLES = 1;
  // Bits of the phase-clock counter.
  localparam int PHASE_CNT_W = 4;

  // Phase of the processor bus cycle.
  typedef enum logic [1:0]
  {
    PH_SETUP = 2'b00,  // Signals changing, strobes idle.
    PH_VALID = 2'b01,  // Signals valid, strobes may assert.
    PH_HOLD  = 2'b10   // Late valid half with write already released.
  } phase_t;

endpackage : bridge_pkg

// ---- core/phase_gen.sv ----
`timescale 1ns/1ps
/*
  Phase clock generator: divides mclk into a square phase clock and
  marks the valid half, the write cut point and the cycle end.
  Assumes a single clock and a synchronous reset; wait freezes the valid half.
*/
module phase_gen #(
  parameter int DIV = bridge_pkg::PHASE_DIV,
  parameter int CUT = bridge_pkg::WR_CUT_CYCLES
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic stall,
  output logic      phase_clk,
  output logic      valid_half,
  output logic      wr_window,
  output logic      cycle_end
);
  import bridge_pkg::*;

  // Half period in mclk cycles.
  localparam logic [PHASE_CNT_W-1:0] HALF = PHASE_CNT_W'(DIV / 2);
  // Last count of the full period.
  localparam logic [PHASE_CNT_W-1:0] LAST = PHASE_CNT_W'(DIV - 1);
  // Last count at which the write strobe may still be low.
  localparam logic [PHASE_CNT_W-1:0] WR_LAST = PHASE_CNT_W'(DIV - 1 - CUT);

  // Position inside the phase period.
  logic [PHASE_CNT_W-1:0] cnt_r;
  // Count that the next edge will load.
  logic [PHASE_CNT_W-1:0] cnt_nxt;
  // Registered phase clock output.
  logic                   ph_r;

  // Next count; a stall holds the count in the valid half, before the write cut.
  always_comb
  begin
    if (stall && cnt_r >= HALF && cnt_r < WR_LAST)
      cnt_nxt = cnt_r;
    else if (cnt_r == LAST)
      cnt_nxt = '0;
    else
      cnt_nxt = cnt_r + PHASE_CNT_W'(1);
  end

  // Count register.
  always_ff @(posedge mclk)
  begin
    if (srst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  // Phase clock is high during the second half, when bus signals are valid.
  always_ff @(posedge mclk)
  begin
    if (srst)
      ph_r <= 1'b0;
    else
      ph_r <= (cnt_nxt >= HALF);
  end

  assign phase_clk  = ph_r;
  // These markers describe the count that the next edge brings, so registers fed
  // from them change in step with the phase clock instead of one cycle late.
  assign valid_half = (cnt_nxt >= HALF);
  assign wr_window  = (cnt_nxt >= HALF) && (cnt_nxt <= WR_LAST);
  // The cycle end marks the last count of the period itself.
  assign cycle_end  = (cnt_r == LAST);

endmodule // phase_gen

// ---- core/pin_sync.sv ----
`timescale 1ns/1ps
/*
  Three-stage synchroniser for a group of pin inputs.
  A change is accepted once the second and third stages agree.
  Assumes the output is read only within the mclk domain.
*/
module pin_sync #(
  parameter int W     = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  import bridge_pkg::*;

  // Stage registers; stage one is only read by stage two.
  logic [W-1:0] st1_r;
  logic [W-1:0] st2_r;
  logic [W-1:0] st3_r;
  // Accepted level.
  logic [W-1:0] lvl_r;

  // Shift chain for metastability settling.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st1_r <= INIT;
      st2_r <= INIT;
      st3_r <= INIT;
    end
    else
    begin
      st1_r <= pin_in;
      st2_r <= st1_r;
      st3_r <= st2_r;
    end
  end

  // Accept each bit only when stages two and three agree, filtering one-cycle glitches.
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge mclk)
      begin
        if (srst)
          lvl_r[i] <= INIT[i];
        else if (st2_r[i] == st3_r[i])
          lvl_r[i] <= st3_r[i];
      end
    end
  endgenerate

  assign level_out = lvl_r;

endmodule // pin_sync

// ---- core/strobe_bridge.sv ----
`timescale 1ns/1ps
/*
  Processor card glue: maps a single phase-clock bus with one read/write
  line onto a backplane with separate read, write, memory and I/O strobes.
  Assumes one 25 MHz clock, synchronous active-high reset, and that the
  processor changes its outputs in the low half of the phase clock.
// What this block does
// (R1) Read and write strobes from phase clock.
// (R2) Processor signals valid in high half only.
// (R3) Dummy reads pass through like real reads.
// (R4) Both strobes high when no transfer.
// (R5) I/O window defaults to page 0xfe.
// (R6) Memory/I/O request decoded from upper address.
// (R7) Cards decode only low eight address bits.
// (R8) Opcode-fetch line held inactive high.
// (R9) Low address and data pass straight through.
// (R10) Upper address bits pass straight through.
// (R11) Backplane interrupt drives processor maskable input.
// (R12) Backplane nonmaskable drives processor nonmaskable input.
// (R13) Bus request, grant and halt unmapped.
// (R14) Wait stretches cycles unless disabled.
// (R15) Fast interrupt exported open collector.
// (R16) Spare-pin exports are individually jumpered.
// (R17) Write strobe released early for hold.
// (R18) Phase clock near 2 MHz, divider set.
// (R19) Far cards condition reset themselves.
// (R20) Memory cards place boot ROM high.
// (R21) Read/write high reads, low writes.
// (R22) Memory request inactive during I/O request.
// (R23) Strobes assert only when phase clock high.
*/
module strobe_bridge #(
  parameter logic [7:0] IO_PAGE  = bridge_pkg::IO_PAGE_RESET,
  parameter int         DIV      = bridge_pkg::PHASE_DIV,
  parameter int         CUT      = bridge_pkg::WR_CUT_CYCLES,
  parameter bit         WAIT_EN  = 1'b1
) (
  input  wire logic                                mclk,
  input  wire logic                                srst,
  input  wire logic [bridge_pkg::ADDR_LO_W-1:0]    cpu_addr,
  input  wire logic [bridge_pkg::ADDR_HI_W-1:0]    cpu_addr_hi,
  input  wire logic [bridge_pkg::DATA_W-1:0]       cpu_data_out,
  output logic      [bridge_pkg::DATA_W-1:0]       cpu_data_in,
  input  wire logic                                cpu_rw,
  input  wire logic                                cpu_fast_irq_n,
  output logic                                     cpu_phase_clk,
  output logic                                     cpu_irq_n,
  output logic                                     cpu_nmi_n,
  output logic      [bridge_pkg::ADDR_LO_W-1:0]    bus_addr,
  output logic      [bridge_pkg::ADDR_HI_W-1:0]    bus_addr_hi,
  input  wire logic [bridge_pkg::DATA_W-1:0]       bus_data_in,
  output logic      [bridge_pkg::DATA_W-1:0]       bus_data_out,
  output logic                                     bus_data_oe,
  output logic                                     bus_rd_n,
  output logic                                     bus_wr_n,
  output logic                                     memory_request_n,
  output logic                                     io_request_n,
  output logic                                     opcode_fetch_n,
  input  wire logic                                bus_int_n,
  input  wire logic                                ext_nonmask_irq_n,
  input  wire logic                                bus_wait_n,
  input  wire logic                                jmp_fast_irq,
  input  wire logic                                jmp_phase,
  input  wire logic                                jmp_rw,
  output logic                                     fast_irq_n_out,
  output logic                                     fast_irq_n_oe,
  output logic                                     phase_pin_out,
  output logic                                     phase_pin_oe,
  output logic                                     rw_pin_out,
  output logic                                     rw_pin_oe
);
  import bridge_pkg::*;

  // Returns true when the upper address byte selects the I/O window.
  function automatic logic is_io(input logic [ADDR_LO_W-1:0] a, input logic [7:0] page);
    is_io = (a[ADDR_LO_W-1:ADDR_LO_W-8] == page);
  endfunction

  // Synchronised backplane inputs: interrupt, nonmaskable and wait.
  logic [2:0] sync_lvl;
  // Phase generator outputs. Valid half and write window look one count ahead,
  // so a strobe registered from them lines up with the phase clock itself.
  // The cycle end marker is the current count, used to check the write cut.
  logic       ph_clk;
  logic       ph_valid;
  logic       ph_wr_ok;
  logic       ph_end;
  // Wait request after synchronisation, gated by the build option.
  logic       stall;
  // Bus phase state.
  phase_t     state_r;
  phase_t     state_nxt;
  // Registered strobe and data outputs.
  logic       rd_n_r;
  logic       wr_n_r;
  logic       memory_request_n_n_r;
  logic       io_request_n_n_r;
  logic       oe_r;
  logic [DATA_W-1:0]    wdata_r;
  logic [DATA_W-1:0]    rdata_r;
  logic [ADDR_LO_W-1:0] addr_r;
  logic [ADDR_HI_W-1:0] addr_hi_r;
  logic       rw_r;

  // Backplane pins are asynchronous to mclk, so they go through the filter.
  pin_sync #(
    .W    (3),
    .INIT (3'h7)
  ) u_sync (
    .mclk      (mclk),
    .srst      (srst),
    .pin_in    ({bus_wait_n, ext_nonmask_irq_n, bus_int_n}),
    .level_out (sync_lvl)
  );

  // Wait is optional: some processors cannot stretch their phase clock.
  assign stall = WAIT_EN && !sync_lvl[2]; // R14

  // Divider producing the phase clock near 2 MHz from mclk.
  phase_gen #(
    .DIV (DIV),
    .CUT (CUT)
  ) u_phase (
    .mclk       (mclk),
    .srst       (srst),
    .stall      (stall),
    .phase_clk  (ph_clk),
    .valid_half (ph_valid),
    .wr_window  (ph_wr_ok),
    .cycle_end  (ph_end)
  ); // R18

  // Next phase state follows the divider markers.
  // Leaving the valid half always returns to setup, even with no write cut,
  // so that no bus cycle is ever skipped.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PH_SETUP: if (ph_valid) state_nxt = PH_VALID;
      PH_VALID:
        if (!ph_valid)
          state_nxt = PH_SETUP;
        else if (!ph_wr_ok)
          state_nxt = PH_HOLD;
      PH_HOLD:  if (!ph_valid) state_nxt = PH_SETUP;
      default:  state_nxt = PH_SETUP;
    endcase
  end

  // Phase state register.
  always_ff @(posedge mclk)
  begin
    if (srst)
      state_r <= PH_SETUP;
    else
      state_r <= state_nxt;
  end

  // Address and direction are captured on entry to the valid half, since
  // the processor only guarantees them there.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      addr_r    <= '0;
      addr_hi_r <= '0;
      rw_r      <= 1'b1;
      wdata_r   <= '0;
    end
    else if (state_r == PH_SETUP && ph_valid) // R2
    begin
      addr_r    <= cpu_addr;    // R9
      addr_hi_r <= cpu_addr_hi; // R10
      rw_r      <= cpu_rw;      // R21
      wdata_r   <= cpu_data_out; // R9
    end
  end

  // Read and write strobes: low only in the valid half, else both high.
  // Dummy reads are not filtered; they appear as ordinary reads.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
    end
    else
    begin
      rd_n_r <= !(state_nxt != PH_SETUP && ph_valid && cpu_rw);    // R1 R23 R3
      wr_n_r <= !(state_nxt == PH_VALID && ph_wr_ok && !cpu_rw);   // R1 R23 R17 R4
    end
  end

  // Request strobes decoded from the upper address during the valid half.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      memory_request_n_n_r <= 1'b1;
      io_request_n_n_r <= 1'b1;
    end
    else if (state_nxt != PH_SETUP && ph_valid)
    begin
      io_request_n_n_r <= !is_io(cpu_addr, IO_PAGE);  // R5 R6
      memory_request_n_n_r <= is_io(cpu_addr, IO_PAGE);   // R6 R22
    end
    else
    begin
      memory_request_n_n_r <= 1'b1;
      io_request_n_n_r <= 1'b1;
    end
  end

  // Data direction: drive the backplane only while writing in the valid half.
  always_ff @(posedge mclk)
  begin
    if (srst)
      oe_r <= 1'b0;
    else
      oe_r <= (state_nxt != PH_SETUP) && ph_valid && !cpu_rw;
  end

  // Read data captured each cycle of a read so the last sample is returned.
  always_ff @(posedge mclk)
  begin
    if (srst)
      rdata_r <= '0;
    else if (!rd_n_r)
      rdata_r <= bus_data_in; // R9
  end

  assign cpu_data_in      = rdata_r;
  assign cpu_phase_clk    = ph_clk;
  assign bus_addr         = addr_r;
  assign bus_addr_hi      = addr_hi_r;
  assign bus_data_out     = wdata_r;
  assign bus_data_oe      = oe_r;
  assign bus_rd_n         = rd_n_r;
  assign bus_wr_n         = wr_n_r;
  assign memory_request_n = memory_request_n_n_r;
  assign io_request_n     = io_request_n_n_r;
  assign opcode_fetch_n   = 1'b1;        // R8
  assign cpu_irq_n        = sync_lvl[0]; // R11
  assign cpu_nmi_n        = sync_lvl[1]; // R12
  // Bus request, grant and halt are deliberately absent. R13

  // Fast interrupt is open collector: only ever pulls low, pull-up is local.
  assign fast_irq_n_out   = 1'b0;                              // R15
  assign fast_irq_n_oe    = jmp_fast_irq && !cpu_fast_irq_n;   // R15 R16
  // Phase clock and direction exports, each behind its own jumper.
  assign phase_pin_out    = ph_clk;
  assign phase_pin_oe     = jmp_phase; // R16
  assign rw_pin_out       = cpu_rw;
  assign rw_pin_oe        = jmp_rw;    // R16

  // Strobes never assert while the phase clock is low.
  a_rd_phase: assert property (@(posedge mclk) disable iff (srst)
    !bus_rd_n |-> cpu_phase_clk)
    else $error("read strobe outside valid half"); // R23
  a_wr_phase: assert property (@(posedge mclk) disable iff (srst)
    !bus_wr_n |-> cpu_phase_clk)
    else $error("write strobe outside valid half"); // R1
  // Strobe direction must agree with the direction latched on entry.
  a_rd_dir: assert property (@(posedge mclk) disable iff (srst)
    !bus_rd_n |-> rw_r)
    else $error("read strobe on a write cycle"); // R21
  a_wr_dir: assert property (@(posedge mclk) disable iff (srst)
    !bus_wr_n |-> !rw_r)
    else $error("write strobe on a read cycle"); // R21
  // Address and data hold still for as long as the write strobe stays low.
  a_wr_hold: assert property (@(posedge mclk) disable iff (srst)
    (!bus_wr_n && $past(!bus_wr_n)) |-> ($stable(bus_addr) && $stable(bus_data_out)))
    else $error("address or data moved under write strobe"); // R17
  // The backplane data lines are driven whenever the write strobe is low.
  a_wr_drive: assert property (@(posedge mclk) disable iff (srst)
    !bus_wr_n |-> bus_data_oe)
    else $error("write strobe without data drive"); // R9
  a_no_both: assert property (@(posedge mclk) disable iff (srst)
    !(!bus_rd_n && !bus_wr_n))
    else $error("read and write strobes together"); // R4
  a_req_excl: assert property (@(posedge mclk) disable iff (srst)
    !io_request_n |-> memory_request_n)
    else $error("memory request during io request"); // R22
  a_wr_cut: assert property (@(posedge mclk) disable iff (srst)
    ph_end |-> bus_wr_n)
    else $error("write strobe held to cycle end"); // R17
  a_idle_high: assert property (@(posedge mclk) disable iff (srst)
    (!ph_valid && $past(!ph_valid)) |-> (bus_rd_n && bus_wr_n))
    else $error("strobe active in setup half"); // R4
  a_io_decode: assert property (@(posedge mclk) disable iff (srst)
    (ph_valid && $past(ph_valid) && cpu_addr[15:8] == IO_PAGE && $stable(cpu_addr))
      |=> !io_request_n || !ph_valid)
    else $error("io window not decoded"); // R6
  a_fetch_high: assert property (@(posedge mclk) disable iff (srst)
    opcode_fetch_n)
    else $error("opcode fetch line driven low"); // R8
  a_fast_irq_n_oc: assert property (@(posedge mclk) disable iff (srst)
    fast_irq_n_oe |-> (jmp_fast_irq && fast_irq_n_out == 1'b0))
    else $error("fast interrupt not open collector"); // R15

endmodule // strobe_bridge

// ---- dv/card_model.sv ----
`timescale 1ns/1ps
/*
  Behavioural backplane card: answers reads, raises interrupts and can hold wait.
  Assumes active-low strobes from the bridge, sampled on mclk, and pull-ups on
  the open-collector interrupt lines.
*/
module card_model (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rd_n,
  input  wire logic        irq_req,
  input  wire logic        nmi_req,
  input  wire logic        slow_card,
  output logic      [7:0]  rd_data,
  output logic             bus_int_n,
  output logic             ext_nonmask_irq_n,
  output logic             bus_wait_n
);
  // Read data depends on the low address byte alone, as a real card decodes it.
  // Between reads the released bus inverts every cycle, so it shows the last value again on alternate cycles.
  // The card answers to the bench's clean synchronous reset, standing in for its own local controller.
  always_ff @(posedge mclk)
  begin
    if (srst)
      rd_data <= 8'h00;
    else if (!bus_rd_n)
      rd_data <= bus_addr[7:0] ^ 8'h5a;
    else
      rd_data <= ~rd_data;
  end

  // Open-collector lines: released means the pull-up wins.
  assign bus_int_n         = ~irq_req;
  assign ext_nonmask_irq_n = ~nmi_req;
  // A slow card holds wait low for as long as the bench commands.
  assign bus_wait_n        = ~slow_card;
endmodule // card_model

// ---- dv/strobe_bridge_test.sv ----
`timescale 1ns/1ps
/*
  Self-checking bench for the strobe bridge: plays the processor side and
  judges strobes, addresses, data and pass-through lines at the backplane.
  Assumes the card model answers reads from the low address byte.
*/
module strobe_bridge_test;
  import bridge_pkg::*;
  logic        mclk           = 1'b0;
  logic        srst           = 1'b1;
  logic [15:0] cpu_addr       = 16'h0000;
  logic [7:0]  cpu_addr_hi    = 8'h00;
  logic [7:0]  cpu_data_out   = 8'h00;
  logic        cpu_rw         = 1'b1;
  logic        cpu_fast_irq_n = 1'b1;
  logic        jmp_fast_irq   = 1'b0;
  logic        jmp_phase      = 1'b0;
  logic        jmp_rw         = 1'b0;
  logic        irq_req        = 1'b0;
  logic        nmi_req        = 1'b0;
  logic        slow_card      = 1'b0;
  logic [7:0]  cpu_data_in, bus_data_in, bus_data_out, bus_addr_hi;
  logic [15:0] bus_addr;
  logic        cpu_phase_clk, cpu_irq_n, cpu_nmi_n, bus_data_oe, bus_rd_n, bus_wr_n;
  logic        memory_request_n, io_request_n, opcode_fetch_n, bus_int_n, ext_nonmask_irq_n;
  logic        bus_wait_n, fast_irq_n_out, fast_irq_n_oe, phase_pin_out, phase_pin_oe;
  logic        rw_pin_out, rw_pin_oe;
  int          bad_count      = 0;
  int          comparisons    = 0;

  // The clock toggles every half period of 20 ns.
  always #20 mclk = ~mclk;

  strobe_bridge dut (.mclk, .srst, .cpu_addr, .cpu_addr_hi, .cpu_data_out, .cpu_data_in, .cpu_rw,
    .cpu_fast_irq_n, .cpu_phase_clk, .cpu_irq_n, .cpu_nmi_n, .bus_addr, .bus_addr_hi, .bus_data_in,
    .bus_data_out, .bus_data_oe, .bus_rd_n, .bus_wr_n, .memory_request_n, .io_request_n,
    .opcode_fetch_n, .bus_int_n, .ext_nonmask_irq_n, .bus_wait_n, .jmp_fast_irq, .jmp_phase, .jmp_rw,
    .fast_irq_n_out, .fast_irq_n_oe, .phase_pin_out, .phase_pin_oe, .rw_pin_out, .rw_pin_oe);

  card_model card (.mclk, .srst, .bus_addr, .bus_rd_n, .irq_req, .nmi_req, .slow_card,
    .rd_data(bus_data_in), .bus_int_n, .ext_nonmask_irq_n, .bus_wait_n);

  // Single-bit comparison.
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus value comparison.
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Inputs move a fixed 1 ns after the rising edge, when outputs have settled.
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One processor cycle: set up in the low half, then count strobe samples in the valid half.
  task automatic bus_cycle(input logic [15:0] a, input logic [7:0] ah, input logic rw,
                           input logic [7:0] d, input logic slow);
    int   n;
    int   hi;
    int   rd;
    int   wr;
    int   mr;
    int   io;
    logic wr_last;
    logic isio;
    n = 0; hi = 0; rd = 0; wr = 0; mr = 0; io = 0; wr_last = 1'b0;
    isio = (a[15:8] == IO_PAGE_RESET);
    while (cpu_phase_clk !== 1'b0 && n < 40)
    begin
      tick;
      n++;
    end
    // The processor only changes its outputs while the phase clock is low.
    cpu_addr = a; cpu_addr_hi = ah; cpu_rw = rw; cpu_data_out = d; slow_card = slow;
    while (cpu_phase_clk !== 1'b1 && n < 80)
    begin
      tick;
      n++;
    end
    while (cpu_phase_clk === 1'b1 && n < 120)
    begin
      hi++;
      rd += int'(!bus_rd_n);
      wr += int'(!bus_wr_n);
      mr += int'(!memory_request_n);
      io += int'(!io_request_n);
      // The slow card lets go after ten valid samples.
      if (hi == 10)
        slow_card = 1'b0;
      if (bus_wr_n === 1'b0)
      begin
        chk_val(bus_data_out, d);
        chk_bit(bus_data_oe, 1'b1);
      end
      wr_last = bus_wr_n;
      tick;
      n++;
    end
    chk_bit(slow ? hi >= 10 : hi == PHASE_DIV / 2, 1'b1);
    chk_val(bus_addr, a);
    chk_val(bus_addr_hi, ah);
    chk_bit(rd == (rw ? hi : 0), 1'b1);
    chk_bit(wr == (rw ? 0 : hi - WR_CUT_CYCLES), 1'b1);
    chk_bit(wr_last, 1'b1);
    chk_bit(io == (isio ? hi : 0), 1'b1);
    chk_bit(mr == (isio ? 0 : hi), 1'b1);
    chk_val({bus_rd_n, bus_wr_n, memory_request_n, io_request_n}, 4'hf);
    if (rw)
      chk_val(cpu_data_in, a[7:0] ^ 8'h5a);
  endtask

  // Idle levels while reset holds or just after it.
  task automatic reset_check;
    chk_val({bus_rd_n, bus_wr_n, memory_request_n, io_request_n, opcode_fetch_n}, 5'h1f);
    chk_val({bus_addr_hi, bus_addr}, 24'h0);
    chk_val({bus_data_oe, cpu_phase_clk, fast_irq_n_oe}, 3'h0);
  endtask

  // Backplane interrupts reach the processor after the synchroniser.
  task automatic irq_check;
    irq_req = 1'b1;
    nmi_req = 1'b1;
    repeat (6) tick;
    chk_val({cpu_irq_n, cpu_nmi_n}, 2'h0);
    irq_req = 1'b0;
    repeat (6) tick;
    chk_val({cpu_irq_n, cpu_nmi_n}, 2'h2);
    nmi_req = 1'b0;
    repeat (6) tick;
    chk_val({cpu_irq_n, cpu_nmi_n, opcode_fetch_n}, 3'h7);
  endtask

  // Spare-pin exports only drive when their jumper is fitted.
  task automatic pin_check;
    cpu_fast_irq_n = 1'b0;
    tick;
    chk_val({fast_irq_n_oe, phase_pin_oe, rw_pin_oe}, 3'h0);
    jmp_fast_irq = 1'b1;
    jmp_phase = 1'b1;
    jmp_rw = 1'b1;
    tick;
    chk_val({fast_irq_n_oe, fast_irq_n_out, phase_pin_oe, rw_pin_oe}, 4'hb);
    chk_bit(phase_pin_out, cpu_phase_clk);
    chk_bit(rw_pin_out, cpu_rw);
    cpu_fast_irq_n = 1'b1;
    tick;
    chk_bit(fast_irq_n_oe, 1'b0);
  endtask

  // Main sequence: seven back-to-back cycles with no idle, as the processor issues them, then interrupt, pin and reset checks.
  initial
  begin
    repeat (4) tick;
    reset_check;
    srst = 1'b0;
    bus_cycle(16'h1234, 8'h00, 1'b1, 8'h00, 1'b0);
    bus_cycle(16'hfe40, 8'h00, 1'b0, 8'ha5, 1'b0);
    bus_cycle(16'hfe41, 8'h00, 1'b1, 8'h00, 1'b0);
    bus_cycle(16'hfd00, 8'h00, 1'b0, 8'h5c, 1'b0);
    // A read at the very top of memory, where the boot code lives, must be answered.
    bus_cycle(16'hffff, 8'h7f, 1'b1, 8'h00, 1'b0);
    bus_cycle(16'h0200, 8'h81, 1'b1, 8'h00, 1'b1);
    bus_cycle(16'hfe02, 8'h00, 1'b0, 8'hc3, 1'b1);
    irq_check;
    pin_check;
    // A second reset in mid-run must bring every strobe back to idle.
    srst = 1'b1;
    repeat (2) tick;
    reset_check;
    srst = 1'b0;
    bus_cycle(16'h00ff, 8'h00, 1'b1, 8'h00, 1'b0);
    tally_and_finish;
  end

  // Watchdog: the whole run needs well under 100 us.
  initial
  begin
    #100000;
    bad_count++;
    tally_and_finish;
  end
endmodule // strobe_bridge_test
